// ===== byte_queue.sv
`timescale 1ns/100ps
module byte_queue #(
  parameter int DEPTH = spi_port_pkg::DEPTH_FIRST
) (
  input wire logic clk_sys_in,  // System clock
  input wire logic resetn_in,   // Synchronous reset, active low
  byte_queue_if.store q         // Fill and drain sides
);
  import spi_port_pkg::*;

  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

  logic [7:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] rd_ptr_q;
  logic [AW:0] cnt_q;
  wire do_wr;
  wire do_rd;

  // ==========================================
  // Handshake decode
  assign q.wr_ready = cnt_q != FULL_CNT;
  assign q.rd_valid = cnt_q != '0;
  assign q.rd_data = mem[rd_ptr_q];
  assign do_wr = q.wr_valid & q.wr_ready;
  assign do_rd = q.rd_valid & q.rd_ready;

  // Storage array, no reset needed
  always_ff @(posedge clk_sys_in) begin
    if (do_wr) begin
      mem[wr_ptr_q] <= q.wr_data;
    end
  end

  // Pointers and fill count
  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      cnt_q <= '0;
    end else begin
      wr_ptr_q <= wr_ptr_q + AW'(do_wr);
      rd_ptr_q <= rd_ptr_q + AW'(do_rd);
      cnt_q <= cnt_q + (AW+1)'(do_wr) - (AW+1)'(do_rd);
    end
  end
endmodule

// ===== byte_queue_if.sv
`timescale 1ns/100ps
interface byte_queue_if;
  logic wr_valid;
  logic wr_ready;
  logic [7:0] wr_data;
  logic rd_valid;
  logic rd_ready;
  logic [7:0] rd_data;

  modport store (
    input wr_valid, wr_data, rd_ready,
    output wr_ready, rd_valid, rd_data
  );
  modport user (
    output wr_valid, wr_data, rd_ready,
    input wr_ready, rd_valid, rd_data
  );
endinterface

// ===== fifo_spi_master_slave_tb.sv
`timescale 1ns/100ps
module fifo_spi_master_slave_tb;
  import spi_port_pkg::*;
  logic clk_sys_in, resetn_in, master_mode_in, cpol_in, cpha_in, lsb_first_in;
  logic three_wire_in, tx_queue_en_in, rx_queue_en_in, tx_wr_valid_in, tx_full_out;
  logic rx_rd_in, rx_data_valid_out, rx_empty_out, rx_len_load_in, cs_ctrl_n_in;
  logic pin_gpio_en_in, cs_gpio_val_in, int_gpio_val_in, udf_clr_in, ovf_clr_in;
  logic underflow_out, overflow_out, busy_out, sclk_out, sclk_oe_out, mosi_out;
  logic mosi_oe_out, mosi_in, miso_in, cs_n_out, cs_oe_out, int_out, slave_sclk_in;
  logic slave_cs_n_in, slave_mosi_in, slave_miso_out, slave_miso_oe_out;
  byte_t tx_wr_data_in, rx_data_out, got, fb, b;
  logic [15:0] rx_len_in;
  logic [1:0] int_mask_in;
  logic [31:0] rs = 32'h0000_0053;
  int fails = 0, compares = 0, cyc = 0, got_n, fk;
  byte_t tx_q[$], rx_q[$];
  spi_fifo_port #(.DEPTH(DEPTH_SECOND)) spi_fifo_port_i (.*);
  // Released data line is pulled up
  spi_remote_dev spi_remote_dev_i (.sclk_in(sclk_out), .cs_n_in(cs_n_out), .cpol_in,
    .cpha_in, .mosi_in(mosi_oe_out ? mosi_out : 1'b1), .miso_out(miso_in),
    .got_out(got), .got_n_out(got_n));
  // Three-wire link: the remote's reply shares the data pin
  assign mosi_in = three_wire_in ? miso_in : 1'b1;
  function automatic byte_t rnd();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs[7:0];
  endfunction
  function automatic byte_t rev(input byte_t v);
    return {v[0], v[1], v[2], v[3], v[4], v[5], v[6], v[7]};
  endfunction
  function automatic byte_t reply(input int i);
    return 8'h3C + 8'(i * 8'h11);
  endfunction
  task automatic chk(input string w, input byte_t e, input byte_t s);
    compares++;
    if (e !== s) begin
      fails++;
      $display("unexpected %s: expected %h seen %h", w, e, s);
    end
  endtask
  task automatic chk_flag(input string w, input logic e, input logic s);
    chk(w, {7'h0, e}, {7'h0, s});
  endtask
  task automatic finish_test();
    if (tx_q.size() + rx_q.size() != 0) begin
      fails++;
      $display("unexpected notes left: expected 0 seen %0d", tx_q.size() + rx_q.size());
    end
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Clock
  initial begin
    clk_sys_in = 1'b0;
    forever #5 clk_sys_in = ~clk_sys_in;
  end
  // Cuts a hang short
  always @(posedge clk_sys_in) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      finish_test();
    end
  end
  // Bytes heard on the wire against the oldest transmit note
  always @(got_n) if (got_n > 0) chk("wire byte", tx_q.pop_front(), got);
  // Popped bytes against the oldest receive note
  always @(posedge clk_sys_in) if (rx_data_valid_out === 1'b1)
    chk("rx byte", rx_q.pop_front(), rx_data_out);
  task automatic xfer(input logic tx_en, input logic rx_en, input int n);
    int base, t;
    base = got_n;
    tx_queue_en_in <= tx_en;
    rx_queue_en_in <= rx_en;
    @(posedge clk_sys_in);
    for (int i = 0; i < n; i++) begin
      b = reply(fk + i);
      if (rx_en) rx_q.push_back(lsb_first_in ? rev(b) : b);
      if (!tx_en) tx_q.push_back(8'hFF);
    end
    fk += n;
    if (tx_en) begin
      for (int i = 0; i < n; i++) begin
        b = rnd();
        tx_wr_valid_in <= 1'b1;
        tx_wr_data_in <= b;
        tx_q.push_back(lsb_first_in ? rev(b) : b);
        @(posedge clk_sys_in);
      end
      tx_wr_valid_in <= 1'b0;
    end else begin
      rx_len_in <= 16'(n);
      rx_len_load_in <= 1'b1;
      @(posedge clk_sys_in);
      rx_len_load_in <= 1'b0;
    end
    t = 0;
    while (got_n < base + n && t < 3000) begin
      @(posedge clk_sys_in);
      t++;
    end
    repeat (20) @(posedge clk_sys_in);
  endtask
  task automatic frame(input logic tx_en, input logic rx_en, input int n);
    cs_ctrl_n_in <= 1'b0;
    fk = 0;
    repeat (2) @(posedge clk_sys_in);
    xfer(tx_en, rx_en, n);
    if (tx_en && rx_en) begin
      chk_flag("idle clock", cpol_in, sclk_out);
      xfer(1'b1, 1'b1, n);
    end
    cs_ctrl_n_in <= 1'b1;
    if (rx_en) begin
      rx_rd_in <= 1'b1;
      repeat (rx_q.size()) @(posedge clk_sys_in);
      rx_rd_in <= 1'b0;
    end
    repeat (4) @(posedge clk_sys_in);
    chk_flag("rx empty", 1'b1, rx_empty_out);
    chk_flag("busy", 1'b0, busy_out);
  endtask
  // Remote master clocks n bits; data out is sampled just before the falling edge
  task automatic slave_bits(input int n);
    for (int i = 0; i < n; i++) begin
      b = rnd();
      slave_mosi_in = b[0];
      #15 slave_sclk_in = 1'b1;
      #15 fb = {fb[6:0], slave_miso_out};
      slave_sclk_in = 1'b0;
    end
  endtask
  // Main sequence
  initial begin
    {master_mode_in, cpol_in, cpha_in, lsb_first_in, three_wire_in, tx_queue_en_in} = '0;
    {rx_queue_en_in, tx_wr_valid_in, rx_rd_in, rx_len_load_in, pin_gpio_en_in} = '0;
    {cs_gpio_val_in, int_gpio_val_in, udf_clr_in, ovf_clr_in} = '0;
    {slave_sclk_in, slave_mosi_in, resetn_in, tx_wr_data_in, rx_len_in} = '0;
    {cs_ctrl_n_in, slave_cs_n_in, int_mask_in} = 4'hF;
    repeat (5) @(posedge clk_sys_in);
    resetn_in <= 1'b1;
    master_mode_in <= 1'b1;
    for (int m = 0; m < 8; m++) begin
      {lsb_first_in, cpol_in, cpha_in} <= 3'(m);
      @(posedge clk_sys_in);
      frame(1'b1, 1'b0, 3);
      $display("test transmit-only mode %0d done", m);
    end
    {lsb_first_in, cpol_in, cpha_in} <= 3'h6;
    @(posedge clk_sys_in);
    frame(1'b1, 1'b1, 2);
    $display("test duplex done");
    {three_wire_in, lsb_first_in, cpol_in, cpha_in} <= 4'h9;
    @(posedge clk_sys_in);
    frame(1'b0, 1'b1, 3);
    $display("test receive-only done");
    pin_gpio_en_in <= 1'b1;
    int_gpio_val_in <= 1'b1;
    repeat (3) @(posedge clk_sys_in);
    chk_flag("gpio select", 1'b0, cs_n_out);
    chk_flag("gpio interrupt", 1'b1, int_out);
    chk_flag("clock drive", 1'b1, sclk_oe_out);
    pin_gpio_en_in <= 1'b0;
    $display("test pin release done");
    master_mode_in <= 1'b0;
    tx_queue_en_in <= 1'b1;
    rx_queue_en_in <= 1'b0;
    int_mask_in <= 2'h1;
    slave_cs_n_in <= 1'b0;
    repeat (4) @(posedge clk_sys_in);
    #7 slave_bits(8);
    @(posedge clk_sys_in);
    chk_flag("slave drive", 1'b1, slave_miso_oe_out);
    slave_cs_n_in <= 1'b1;
    repeat (10) @(posedge clk_sys_in);
    chk("fill byte", 8'hFF, fb);
    chk_flag("underflow", 1'b1, underflow_out);
    chk_flag("interrupt", 1'b1, int_out);
    chk_flag("overflow", 1'b0, overflow_out);
    udf_clr_in <= 1'b1;
    @(posedge clk_sys_in);
    udf_clr_in <= 1'b0;
    repeat (3) @(posedge clk_sys_in);
    chk_flag("cleared", 1'b0, underflow_out);
    $display("test slave underflow done");
    rx_queue_en_in <= 1'b1;
    slave_cs_n_in <= 1'b0;
    repeat (4) @(posedge clk_sys_in);
    #7 slave_bits(8 * (DEPTH_SECOND + 1));
    @(posedge clk_sys_in);
    slave_cs_n_in <= 1'b1;
    repeat (10) @(posedge clk_sys_in);
    chk_flag("overflow set", 1'b1, overflow_out);
    $display("test slave overflow done");
    finish_test();
  end
endmodule

// ===== spi_fifo_port.sv
`timescale 1ns/100ps
module spi_fifo_port #(
  parameter int DEPTH = spi_port_pkg::DEPTH_FIRST  // default DEPTH_FIRST; the testbench uses DEPTH_SECOND
) (
  input wire logic clk_sys_in,                   // System clock
  input wire logic resetn_in,                    // Reset, active low; synchronous except in the link clock half
  input wire logic master_mode_in,               // 1 master, 0 slave
  input wire logic cpol_in,                      // Clock idle level
  input wire logic cpha_in,                      // Clock phase
  input wire logic lsb_first_in,                 // Bit order
  input wire logic three_wire_in,                // Master data in on shared pin
  input wire logic tx_queue_en_in,               // Transmit queue enable
  input wire logic rx_queue_en_in,               // Receive queue enable
  input wire logic tx_wr_valid_in,               // Push strobe into transmit queue
  input wire spi_port_pkg::byte_t tx_wr_data_in, // Byte to push
  output logic tx_full_out,                      // Transmit queue full
  input wire logic rx_rd_in,                     // Pop strobe from receive queue
  output spi_port_pkg::byte_t rx_data_out,       // Popped byte
  output logic rx_data_valid_out,                // Popped byte valid pulse
  output logic rx_empty_out,                     // Receive queue empty
  input wire logic [15:0] rx_len_in,             // Bytes to fetch in receive-only
  input wire logic rx_len_load_in,               // Load strobe for rx_len_in
  input wire logic cs_ctrl_n_in,                 // Software chip select level
  input wire logic pin_gpio_en_in,               // Release select and interrupt pins, master mode only
  input wire logic cs_gpio_val_in,               // GPIO level for select pin
  input wire logic int_gpio_val_in,              // GPIO level for interrupt pin
  input wire logic [1:0] int_mask_in,            // Bit0 underflow, bit1 overflow
  input wire logic udf_clr_in,                   // Clear underflow flag
  input wire logic ovf_clr_in,                   // Clear overflow flag
  output logic underflow_out,                    // Sticky underflow flag
  output logic overflow_out,                     // Sticky overflow flag
  output logic busy_out,                         // Transfer in progress
  output logic sclk_out,                         // Master serial clock
  output logic sclk_oe_out,                      // Master drives clock
  output logic mosi_out,                         // Master data out
  output logic mosi_oe_out,                      // Master drives data pin
  input wire logic mosi_in,                      // Data pin readback, three-wire
  input wire logic miso_in,                      // Master data in, four-wire
  output logic cs_n_out,                         // chip_select_n_line drive
  output logic cs_oe_out,                        // Select pin driven
  output logic int_out,                          // Interrupt pin
  input wire logic slave_sclk_in,                // Link clock from remote master
  input wire logic slave_cs_n_in,                // chip_select_n_line as slave
  input wire logic slave_mosi_in,                // Slave data in
  output logic slave_miso_out,                   // Slave data out
  output logic slave_miso_oe_out                 // Slave drives data out
);
  import spi_port_pkg::*;

  byte_queue_if txq();
  byte_queue_if rxq();

  // ==========================================
  // Queues: transmit_queue and receive_queue
  byte_queue #(.DEPTH(DEPTH)) u_tx_queue (
    .clk_sys_in(clk_sys_in),
    .resetn_in(resetn_in),
    .q(txq.store)
  );
  byte_queue #(.DEPTH(DEPTH)) u_rx_queue (
    .clk_sys_in(clk_sys_in),
    .resetn_in(resetn_in),
    .q(rxq.store)
  );

  // ==========================================
  // Pin synchronisers into system clock
  logic [1:0] mosi_s_q;
  logic [1:0] miso_s_q;
  logic [1:0] cs_s_q;
  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      mosi_s_q <= '0;
      miso_s_q <= '0;
      cs_s_q <= 2'h3;
    end else begin
      mosi_s_q <= {mosi_s_q[0], mosi_in};
      miso_s_q <= {miso_s_q[0], miso_in};
      cs_s_q <= {cs_s_q[0], slave_cs_n_in};
    end
  end

  // ==========================================
  // Mode decode
  wire tx_only;
  wire rx_only;
  wire duplex;
  wire rx_space;
  byte_t tx_head;
  assign tx_only = tx_queue_en_in & ~rx_queue_en_in;
  assign rx_only = ~tx_queue_en_in & rx_queue_en_in;
  assign duplex = tx_queue_en_in & rx_queue_en_in;
  assign rx_space = rxq.wr_ready;
  assign tx_head = lsb_first_in ? bit_rev(txq.rd_data) : txq.rd_data;

  // ==========================================
  // Master sequencer
  master_state_e m_state_q;
  master_state_e m_state_d;
  logic [7:0] half_q;
  logic phase_q;
  logic [2:0] bit_q;
  logic [1:0] lag_q;
  logic [2:0] cap_bit_q;
  logic [LEN_W-1:0] rx_left_q;
  byte_t m_tx_sh_q;
  byte_t m_rx_sh_q;
  logic sclk_q;
  logic mosi_q;
  wire m_run;
  wire m_can_go;
  wire m_start;
  wire half_done;
  wire m_lead;
  wire m_trail;
  wire m_last;
  wire samp_ev;
  wire shift_ev;
  wire m_rx_bit;
  wire m_push;
  byte_t m_rx_byte;
  byte_t m_load;

  assign m_run = m_state_q == M_RUN;
  // Byte boundary gate: pause while data or space is missing
  assign m_can_go = master_mode_in & (lag_q == '0) & (
    (tx_only & txq.rd_valid) |
    (rx_only & rx_space & (rx_left_q != '0)) |
    (duplex & txq.rd_valid & rx_space));
  assign m_start = (m_state_q == M_IDLE) & m_can_go;
  assign half_done = m_run & (half_q == HALF_LAST);
  assign m_lead = half_done & ~phase_q;
  assign m_trail = half_done & phase_q;
  assign m_last = m_trail & (bit_q == 3'h7);
  assign samp_ev = cpha_in ? m_trail : m_lead;
  assign shift_ev = cpha_in ? m_lead : (m_trail & ~m_last);
  assign m_rx_bit = three_wire_in ? mosi_s_q[1] : miso_s_q[1];
  assign m_rx_byte = lsb_first_in ? bit_rev({m_rx_sh_q[6:0], m_rx_bit})
                                  : {m_rx_sh_q[6:0], m_rx_bit};
  assign m_push = master_mode_in & lag_q[1] & (cap_bit_q == 3'h7) & rx_queue_en_in;
  assign m_load = tx_queue_en_in ? tx_head : FILL_BYTE;

  // Next state
  always_comb begin
    case (m_state_q)
      M_IDLE: m_state_d = m_start ? M_RUN : M_IDLE;
      M_RUN: m_state_d = m_last ? M_IDLE : M_RUN;
      default: m_state_d = M_IDLE;
    endcase
  end

  // Sequencer registers
  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      m_state_q <= M_IDLE;
      half_q <= '0;
      phase_q <= 1'b0;
      bit_q <= '0;
    end else begin
      m_state_q <= m_state_d;
      half_q <= (m_run & ~half_done) ? half_q + 8'h01 : 8'h00;
      phase_q <= m_start ? 1'b0 : (phase_q ^ half_done);
      bit_q <= m_start ? 3'h0 : (bit_q + 3'(m_trail));
    end
  end

  // Requested length for receive-only
  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      rx_left_q <= RX_LEFT_RST;
    end else if (rx_len_load_in) begin
      rx_left_q <= rx_len_in;
    end else if (m_start & rx_only) begin
      rx_left_q <= rx_left_q - 16'h0001;
    end
  end

  // Serial clock, held at idle level between bytes
  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      sclk_q <= SCLK_RST;
    end else if (!m_run) begin
      sclk_q <= cpol_in;
    end else if (half_done) begin
      sclk_q <= ~sclk_q;
    end
  end

  // Transmit shifter
  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      m_tx_sh_q <= FILL_BYTE;
      mosi_q <= 1'b1;
    end else if (m_start) begin
      m_tx_sh_q <= cpha_in ? m_load : {m_load[6:0], 1'b0};
      mosi_q <= cpha_in ? mosi_q : m_load[7];
    end else if (shift_ev) begin
      m_tx_sh_q <= {m_tx_sh_q[6:0], 1'b0};
      mosi_q <= m_tx_sh_q[7];
    end
  end

  // Receive capture, delayed to cover the input synchroniser
  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      lag_q <= '0;
      cap_bit_q <= '0;
      m_rx_sh_q <= '0;
    end else begin
      lag_q <= {lag_q[0], samp_ev};
      if (lag_q[1]) begin
        cap_bit_q <= cap_bit_q + 3'h1;
        m_rx_sh_q <= {m_rx_sh_q[6:0], m_rx_bit};
      end
    end
  end

  // ==========================================
  // Slave side, system clock half
  byte_t hold_q;
  logic hold_full_q;
  logic rx_tog_l_q;
  logic ack_tog_l_q;
  logic udf_tog_l_q;
  logic [2:0] rx_tog_s_q;
  logic [2:0] ack_tog_s_q;
  logic [2:0] udf_tog_s_q;
  wire s_pop;
  wire s_rx_ev;
  wire s_ack_ev;
  wire s_udf_ev;
  wire s_push;
  wire ovf_set;
  byte_t rxw_l_q;
  byte_t s_rx_byte;

  assign s_pop = ~master_mode_in & ~hold_full_q & tx_queue_en_in & txq.rd_valid;
  assign s_rx_ev = rx_tog_s_q[2] ^ rx_tog_s_q[1];
  assign s_ack_ev = ack_tog_s_q[2] ^ ack_tog_s_q[1];
  assign s_udf_ev = udf_tog_s_q[2] ^ udf_tog_s_q[1];
  assign s_push = ~master_mode_in & s_rx_ev & rx_queue_en_in & rx_space;
  assign ovf_set = ~master_mode_in & s_rx_ev & rx_queue_en_in & ~rx_space;
  assign s_rx_byte = lsb_first_in ? bit_rev(rxw_l_q) : rxw_l_q;

  // Event toggles back from the link clock
  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      rx_tog_s_q <= '0;
      ack_tog_s_q <= '0;
      udf_tog_s_q <= '0;
    end else begin
      rx_tog_s_q <= {rx_tog_s_q[1:0], rx_tog_l_q};
      ack_tog_s_q <= {ack_tog_s_q[1:0], ack_tog_l_q};
      udf_tog_s_q <= {udf_tog_s_q[1:0], udf_tog_l_q};
    end
  end

  // Hold word offered to the link, stable until acknowledged
  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      hold_q <= FILL_BYTE;
      hold_full_q <= 1'b0;
    end else if (s_pop) begin
      hold_q <= tx_head;
      hold_full_q <= 1'b1;
    end else if (s_ack_ev) begin
      hold_full_q <= 1'b0;
    end
  end

  // Queue steering between master and slave
  assign txq.wr_valid = tx_wr_valid_in & tx_queue_en_in;
  assign txq.wr_data = tx_wr_data_in;
  assign txq.rd_ready = master_mode_in ? (m_start & tx_queue_en_in) : s_pop;
  assign rxq.wr_valid = m_push | s_push;
  assign rxq.wr_data = master_mode_in ? m_rx_byte : s_rx_byte;
  assign rxq.rd_ready = rx_rd_in;

  // ==========================================
  // Slave side, link clock half
  wire lclk;
  logic [2:0] bit_l_q;
  byte_t rx_l_q;
  byte_t tx_l_q;
  logic miso_l_q;
  logic [1:0] hold_s_l_q;
  logic [1:0] en_s_l_q;
  wire l_load;
  byte_t l_byte;

  // Sampling edge rises on this clock in every mode
  assign lclk = slave_sclk_in ^ cpol_in ^ cpha_in;
  assign l_load = bit_l_q == 3'h0;
  assign l_byte = hold_s_l_q[1] ? hold_q : FILL_BYTE;

  // Bit counter and input shifter, cleared while deselected
  always_ff @(posedge lclk or posedge slave_cs_n_in) begin
    if (slave_cs_n_in) begin
      bit_l_q <= '0;
      rx_l_q <= '0;
    end else begin
      bit_l_q <= bit_l_q + 3'h1;
      rx_l_q <= {rx_l_q[6:0], slave_mosi_in};
    end
  end

  // Completed byte and its event toggle
  always_ff @(posedge lclk or negedge resetn_in) begin
    if (!resetn_in) begin
      rxw_l_q <= '0;
      rx_tog_l_q <= 1'b0;
    end else if (bit_l_q == 3'h7) begin
      rxw_l_q <= {rx_l_q[6:0], slave_mosi_in};
      rx_tog_l_q <= ~rx_tog_l_q;
    end
  end

  // Output shifter on the launching edge
  always_ff @(negedge lclk or posedge slave_cs_n_in) begin
    if (slave_cs_n_in) begin
      tx_l_q <= FILL_BYTE;
      miso_l_q <= 1'b1;
    end else if (l_load) begin
      tx_l_q <= {l_byte[6:0], 1'b0};
      miso_l_q <= l_byte[7];
    end else begin
      tx_l_q <= {tx_l_q[6:0], 1'b0};
      miso_l_q <= tx_l_q[7];
    end
  end

  // Hold status synchroniser and take or underflow toggles
  always_ff @(negedge lclk or negedge resetn_in) begin
    if (!resetn_in) begin
      hold_s_l_q <= '0;
      en_s_l_q <= '0;
      ack_tog_l_q <= 1'b0;
      udf_tog_l_q <= 1'b0;
    end else begin
      hold_s_l_q <= {hold_s_l_q[0], hold_full_q};
      en_s_l_q <= {en_s_l_q[0], tx_queue_en_in};
      if (!slave_cs_n_in && l_load && hold_s_l_q[1]) begin
        ack_tog_l_q <= ~ack_tog_l_q;
      end
      if (!slave_cs_n_in && l_load && !hold_s_l_q[1] && en_s_l_q[1]) begin
        udf_tog_l_q <= ~udf_tog_l_q;
      end
    end
  end

  // ==========================================
  // Flags, pins and status outputs
  logic udf_q;
  logic ovf_q;
  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      udf_q <= 1'b0;
      ovf_q <= 1'b0;
    end else begin
      udf_q <= (udf_q & ~udf_clr_in) | (~master_mode_in & s_udf_ev);
      ovf_q <= (ovf_q & ~ovf_clr_in) | ovf_set;
    end
  end

  // Registered pin and status drive
  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      cs_n_out <= CS_N_RST;
      cs_oe_out <= 1'b0;
      int_out <= 1'b0;
      sclk_oe_out <= 1'b0;
      mosi_oe_out <= 1'b0;
      slave_miso_oe_out <= 1'b0;
      busy_out <= 1'b0;
      tx_full_out <= 1'b0;
      rx_empty_out <= 1'b1;
      rx_data_out <= '0;
      rx_data_valid_out <= 1'b0;
    end else begin
      cs_n_out <= (master_mode_in & pin_gpio_en_in) ? cs_gpio_val_in : cs_ctrl_n_in;
      cs_oe_out <= master_mode_in;
      int_out <= (master_mode_in & pin_gpio_en_in) ? int_gpio_val_in
                 : |({ovf_q, udf_q} & int_mask_in);
      sclk_oe_out <= master_mode_in;
      mosi_oe_out <= master_mode_in & tx_queue_en_in;
      slave_miso_oe_out <= ~master_mode_in & ~cs_s_q[1] & tx_queue_en_in;
      busy_out <= m_run | (lag_q != '0) | (~master_mode_in & ~cs_s_q[1]);
      tx_full_out <= ~txq.wr_ready;
      rx_empty_out <= ~rxq.rd_valid;
      rx_data_out <= (rx_rd_in & rxq.rd_valid) ? rxq.rd_data : rx_data_out;
      rx_data_valid_out <= rx_rd_in & rxq.rd_valid;
    end
  end

  assign underflow_out = udf_q;
  assign overflow_out = ovf_q;
  assign sclk_out = sclk_q;
  assign mosi_out = mosi_q;
  assign slave_miso_out = miso_l_q;

  // ==========================================
  // Checks
  logic [9:0] byte_cyc_q;
  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      byte_cyc_q <= '0;
    end else begin
      byte_cyc_q <= m_run ? byte_cyc_q + 10'h001 : 10'h000;
    end
  end

  sequence idle_settled;
    !m_run && $past(!m_run) && $stable(cpol_in);
  endsequence
  sequence starved_boundary;
    (m_state_q == M_IDLE) && master_mode_in && !m_can_go;
  endsequence

  idle_level_a: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    idle_settled |-> sclk_out == cpol_in) else $error("clock not at idle level");
  tx_pause_a: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    starved_boundary and (tx_only && !txq.rd_valid) |=> !m_run)
    else $error("clock ran with empty transmit queue");
  rx_pause_a: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    starved_boundary and (rx_only && !rx_space) |=> !m_run)
    else $error("clock ran with full receive queue");
  duplex_pause_a: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    (m_state_q == M_IDLE) && master_mode_in && duplex && !(txq.rd_valid && rx_space)
    |=> !m_run) else $error("duplex ran while starved");
  tx_only_a: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    master_mode_in && !rx_queue_en_in |-> !rxq.wr_valid)
    else $error("receive stored in transmit-only mode");
  rx_quiet_a: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    master_mode_in && !tx_queue_en_in ##1 $stable(tx_queue_en_in) |-> !mosi_oe_out)
    else $error("data driven in receive-only mode");
  byte_len_a: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    m_last |-> byte_cyc_q == 10'(BYTE_CYC - 1)) else $error("byte length wrong");
  udf_sticky_a: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    underflow_out && !udf_clr_in |=> underflow_out) else $error("underflow flag lost");
  ovf_set_a: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    ovf_set |=> overflow_out) else $error("overflow not flagged");
  cs_release_a: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    master_mode_in && pin_gpio_en_in |=> cs_n_out == $past(cs_gpio_val_in))
    else $error("select pin not released");
  fill_byte_a: assert property (@(negedge lclk) disable iff (slave_cs_n_in)
    l_load && !hold_s_l_q[1] |=> miso_l_q == FILL_BYTE[7] && tx_l_q == {FILL_BYTE[6:0], 1'b0})
    else $error("fill byte not driven");
endmodule

// ===== spi_port_pkg.sv
package spi_port_pkg;

  // ==========================================
  // Data and queue sizing
  localparam int BYTE_W = 8;
  localparam int DEPTH_FIRST = 1024;
  localparam int DEPTH_SECOND = 64;
  localparam int LEN_W = 16;
  typedef logic [BYTE_W-1:0] byte_t;
  localparam byte_t FILL_BYTE = 8'hFF;
  localparam logic [LEN_W-1:0] RX_LEFT_RST = 16'h0000;

  // ==========================================
  // Timing of the master serial clock
  localparam int SYS_PERIOD_NS = 10;
  localparam int SCLK_HALF_NS = 50;
  localparam int SCLK_HALF_CYC = (SCLK_HALF_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
  localparam logic [7:0] HALF_LAST = 8'(SCLK_HALF_CYC - 1);
  localparam int BYTE_CYC = 2 * BYTE_W * SCLK_HALF_CYC;

  // ==========================================
  // Reset values of pins
  localparam logic SCLK_RST = 1'b0;
  localparam logic CS_N_RST = 1'b1;

  // ==========================================
  // Master sequencer states
  typedef enum logic [1:0] {
    M_IDLE = 2'h1,
    M_RUN = 2'h2
  } master_state_e;

  // Reverses bit order for least significant bit first transfers
  function automatic byte_t bit_rev(input byte_t b);
    byte_t r;
    r = '0;
    for (int i = 0; i < BYTE_W; i++) begin
      r[i] = b[BYTE_W-1-i];
    end
    return r;
  endfunction

endpackage

// ===== spi_remote_dev.sv
`timescale 1ns/100ps
// ==========
// Remote serial device facing the block in master mode
module spi_remote_dev (
  input wire logic sclk_in,    // Clock from block
  input wire logic cs_n_in,    // Select from block
  input wire logic cpol_in,    // Clock idle level
  input wire logic cpha_in,    // Clock phase
  input wire logic mosi_in,    // Data from block
  output logic miso_out,       // Data to block
  output logic [7:0] got_out,  // Last byte heard
  output int got_n_out         // Bytes heard
);
  logic [7:0] tx_sr, rx_sr;
  int lb, rc, k;
  // Puts out the next reply bit, reloading at a byte boundary
  task automatic launch();
    if (lb == 0) begin
      tx_sr = 8'h3C + 8'(k * 8'h11);
      k++;
    end
    miso_out = tx_sr[7];
    tx_sr = tx_sr << 1;
    lb = (lb + 1) % 8;
  endtask
  initial begin
    miso_out = 1'b1;
    got_n_out = 0;
  end
  // Frame edges; a released line shows the inverse of its last bit
  always @(cs_n_in) begin
    if (!cs_n_in) begin
      lb = 0;
      rc = 0;
      k = 0;
      if (!cpha_in) launch();
    end else miso_out = ~miso_out;
  end
  // Samples on the mode's sampling edge, launches on the other
  always @(sclk_in) begin
    if (!cs_n_in) begin
      if (sclk_in ^ cpol_in ^ cpha_in) begin
        rx_sr = {rx_sr[6:0], mosi_in};
        rc++;
        if (rc % 8 == 0) begin
          got_out = rx_sr;
          got_n_out++;
        end
      end else launch();
    end
  end
endmodule
